// ### design/usb_nak_pkg.sv
// Shared constants and types for the forced-NAK list and endpoint 0 port.
// Assumes a byte-addressed register port with 32-bit data words.
package usb_nak_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_LIST_A = 8'h60;
    localparam logic [ADDR_W-1:0] ADDR_LIST_B = 8'h64;
    localparam logic [ADDR_W-1:0] ADDR_EP0_PORT = 8'h80;
    localparam logic [ADDR_W-1:0] ADDR_FIFO_STATUS = 8'h90;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int ENABLE_BIT = 31;
    localparam int SLOT_W = 4;
    localparam int SLOTS = 6;
    localparam int BYTE_W = 8;
    localparam int STAT_OUT_LSB = 8;
    localparam logic [DATA_W-1:0] LIST_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] LIST_WMASK = 32'h80ff_ffff;
    localparam logic [SLOT_W-1:0] EP_NONE = 4'h0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic is_in;
        logic [SLOT_W-1:0] ep;
    } token_t;

    typedef struct packed {
        logic valid;
        logic forced_nak;
    } verdict_t;

endpackage

// ### design/nak_list_match.sv
// One forced-NAK list: six endpoint slots and an enable bit.
// Assumes the caller hands it the stored list word and a token endpoint.
`timescale 1ns/1ps
`default_nettype none
module nak_list_match (
    // List word and token endpoint
    input wire logic [usb_nak_pkg::DATA_W-1:0] list,
    input wire logic [usb_nak_pkg::SLOT_W-1:0] ep,
    // Result
    output logic hit
);
    logic [usb_nak_pkg::SLOTS-1:0] slot_hit;

    // ------------------------------------------------------------
    // Slot compare
    // ------------------------------------------------------------
    // A zero slot is never a candidate, so a cleared list cannot catch
    // control endpoint 0 by accident.
    genvar i;
    generate
        for (i = 0; i < usb_nak_pkg::SLOTS; i++) begin : g_slot
            wire logic [usb_nak_pkg::SLOT_W-1:0] slot_ep;
            assign slot_ep = list[i*usb_nak_pkg::SLOT_W +: usb_nak_pkg::SLOT_W];
            assign slot_hit[i] = (slot_ep != usb_nak_pkg::EP_NONE) &&
                                 (slot_ep == ep);
        end
    endgenerate

    // Enable only governs this list's own slots.
    assign hit = list[usb_nak_pkg::ENABLE_BIT] && (|slot_hit);
endmodule
`default_nettype wire

// ### design/usb_nak_fifo.sv
// Forced-NAK lists and the control endpoint 0 byte FIFO port.
// Assumes a USB packet engine presents decoded tokens and moves endpoint 0
// bytes on a simple pop/push port, all on the controller clock.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module usb_nak_fifo #(
    parameter int DEPTH = 16
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Register port
    input wire logic [usb_nak_pkg::ADDR_W-1:0] addr,
    input wire logic [usb_nak_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [usb_nak_pkg::DATA_W-1:0] rdata_q,
    // Token from the packet engine
    input wire usb_nak_pkg::token_t token,
    input wire logic normal_nak,
    output usb_nak_pkg::verdict_t verdict_q,
    // Endpoint 0 bytes toward the host (IN)
    input wire logic in_pop,
    output logic [usb_nak_pkg::BYTE_W-1:0] in_byte_q,
    output logic in_byte_valid_q,
    output logic in_empty_q,
    // Endpoint 0 bytes from the host (OUT)
    input wire logic out_push,
    input wire logic [usb_nak_pkg::BYTE_W-1:0] out_byte,
    output logic out_full_q
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
    localparam logic [CW-1:0] ONE_C = CW'(1);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [usb_nak_pkg::DATA_W-1:0] list_a_q;
    logic [usb_nak_pkg::DATA_W-1:0] list_b_q;
    logic [usb_nak_pkg::BYTE_W-1:0] in_mem [DEPTH];
    logic [usb_nak_pkg::BYTE_W-1:0] out_mem [DEPTH];
    logic [PW-1:0] in_wp_q;
    logic [PW-1:0] in_rp_q;
    logic [CW-1:0] in_cnt_q;
    logic [PW-1:0] out_wp_q;
    logic [PW-1:0] out_rp_q;
    logic [CW-1:0] out_cnt_q;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire logic sel_a;
    wire logic sel_b;
    wire logic sel_port;
    wire logic sel_stat;
    assign sel_a = (addr == usb_nak_pkg::ADDR_LIST_A);
    assign sel_b = (addr == usb_nak_pkg::ADDR_LIST_B);
    assign sel_port = (addr == usb_nak_pkg::ADDR_EP0_PORT);
    assign sel_stat = (addr == usb_nak_pkg::ADDR_FIFO_STATUS);

    // ------------------------------------------------------------
    // List writes
    // ------------------------------------------------------------
    // Reserved bits 30:24 are masked so they always read back zero.
    wire logic [usb_nak_pkg::DATA_W-1:0] list_wval;
    assign list_wval = wdata & usb_nak_pkg::LIST_WMASK;

    // Each list has its own strobe, so one never disturbs the other.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            list_a_q <= usb_nak_pkg::LIST_RESET;
            list_b_q <= usb_nak_pkg::LIST_RESET;
        end else if (ce) begin
            if (wr && sel_a) begin
                list_a_q <= list_wval;
            end
            if (wr && sel_b) begin
                list_b_q <= list_wval;
            end
        end
    end

    // ------------------------------------------------------------
    // Token matching
    // ------------------------------------------------------------
    wire logic hit_a;
    wire logic hit_b;
    wire logic force_now;

    nak_list_match u_match_a (
        .list (list_a_q),
        .ep (token.ep),
        .hit (hit_a)
    );

    nak_list_match u_match_b (
        .list (list_b_q),
        .ep (token.ep),
        .hit (hit_b)
    );

    // Only IN tokens are affected; OUT and SETUP pass untouched.
    assign force_now = token.valid && token.is_in && (hit_a || hit_b);

    // A forced verdict ignores whatever the endpoint itself would answer,
    // which is why normal_nak only feeds the non-forced case.
    wire usb_nak_pkg::verdict_t verdict_d;
    assign verdict_d.valid = token.valid;
    assign verdict_d.forced_nak = force_now || (token.valid &&
                                  normal_nak && !force_now);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            verdict_q <= '0;
        end else if (ce) begin
            verdict_q <= verdict_d;
        end
    end

    // ------------------------------------------------------------
    // IN FIFO: CPU loads, engine drains
    // ------------------------------------------------------------
    // While a NAK verdict stands the engine's pop is refused, so a NAKed
    // IN never consumes data and the toggle the engine keeps stays put.
    wire logic in_push_ok;
    wire logic in_pop_ok;
    assign in_push_ok = wr && sel_port && (in_cnt_q != DEPTH_C);
    assign in_pop_ok = in_pop && (in_cnt_q != '0) &&
                       !(verdict_q.valid && verdict_q.forced_nak);

    always_ff @(posedge clk) begin
        if (ce && in_push_ok) begin
            in_mem[in_wp_q] <= wdata[usb_nak_pkg::BYTE_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            in_wp_q <= '0;
            in_rp_q <= '0;
            in_cnt_q <= '0;
        end else if (ce) begin
            if (in_push_ok) begin
                in_wp_q <= in_wp_q + PW'(1);
            end
            if (in_pop_ok) begin
                in_rp_q <= in_rp_q + PW'(1);
            end
            in_cnt_q <= in_cnt_q + (in_push_ok ? ONE_C : '0)
                        - (in_pop_ok ? ONE_C : '0);
        end
    end

    // Popped byte is registered so the engine sees it one cycle later.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            in_byte_q <= '0;
            in_byte_valid_q <= 1'b0;
            in_empty_q <= 1'b1;
        end else if (ce) begin
            in_byte_valid_q <= in_pop_ok;
            if (in_pop_ok) begin
                in_byte_q <= in_mem[in_rp_q];
            end
            in_empty_q <= (in_cnt_q + (in_push_ok ? ONE_C : '0)
                          - (in_pop_ok ? ONE_C : '0)) == '0;
        end
    end

    // ------------------------------------------------------------
    // OUT FIFO: engine loads, CPU unloads
    // ------------------------------------------------------------
    // A read of an empty port returns zero and moves nothing.
    wire logic out_push_ok;
    wire logic out_pop_ok;
    assign out_push_ok = out_push && (out_cnt_q != DEPTH_C);
    assign out_pop_ok = rd && sel_port && (out_cnt_q != '0);

    always_ff @(posedge clk) begin
        if (ce && out_push_ok) begin
            out_mem[out_wp_q] <= out_byte;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_wp_q <= '0;
            out_rp_q <= '0;
            out_cnt_q <= '0;
        end else if (ce) begin
            if (out_push_ok) begin
                out_wp_q <= out_wp_q + PW'(1);
            end
            if (out_pop_ok) begin
                out_rp_q <= out_rp_q + PW'(1);
            end
            out_cnt_q <= out_cnt_q + (out_push_ok ? ONE_C : '0)
                         - (out_pop_ok ? ONE_C : '0);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_full_q <= 1'b0;
        end else if (ce) begin
            out_full_q <= (out_cnt_q + (out_push_ok ? ONE_C : '0)
                          - (out_pop_ok ? ONE_C : '0)) == DEPTH_C;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // The port word carries the byte in its low lane; bits above are zero.
    wire logic [usb_nak_pkg::DATA_W-1:0] port_word;
    wire logic [usb_nak_pkg::DATA_W-1:0] stat_word;
    wire logic [usb_nak_pkg::DATA_W-1:0] rdata_d;
    assign port_word = out_pop_ok ?
        usb_nak_pkg::DATA_W'(out_mem[out_rp_q]) : '0;
    assign stat_word = usb_nak_pkg::DATA_W'(in_cnt_q) |
        (usb_nak_pkg::DATA_W'(out_cnt_q) << usb_nak_pkg::STAT_OUT_LSB);
    assign rdata_d = !rd ? '0 :
                     sel_a ? list_a_q :
                     sel_b ? list_b_q :
                     sel_port ? port_word :
                     sel_stat ? stat_word : '0;

    // Data stand only in the cycle after the strobe, then fall to zero.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= '0;
        end else if (ce) begin
            rdata_q <= rdata_d;
        end
    end

endmodule
`default_nettype wire

// ### tb/usb_nak_fifo_asserts.sv
// Assertions on the forced-NAK lists and the endpoint 0 port.
// Assumes it is bound to usb_nak_fifo and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module usb_nak_fifo_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Observed ports
    input wire logic ce,
    input wire logic [usb_nak_pkg::ADDR_W-1:0] addr,
    input wire logic rd,
    input wire logic [usb_nak_pkg::DATA_W-1:0] rdata_q,
    input wire usb_nak_pkg::token_t token,
    input wire logic normal_nak,
    input wire usb_nak_pkg::verdict_t verdict_q,
    input wire logic in_pop,
    input wire logic in_byte_valid_q,
    input wire logic in_empty_q
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    // One clock domain, so reset silences every check at once.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_tok;
        ce && token.valid;
    endsequence
    sequence s_nak_up;
        verdict_q.valid && verdict_q.forced_nak;
    endsequence
    chk_verdict_next: assert property (s_tok |=> verdict_q.valid)
        else $error("verdict missing");
    chk_verdict_one: assert property (
        ce && !token.valid |=> !verdict_q.valid)
        else $error("stray verdict");
    chk_normal_kept: assert property (
        s_tok ##0 normal_nak |=> verdict_q.forced_nak)
        else $error("normal nak lost");
    chk_out_only_in: assert property (
        s_tok ##0 (!token.is_in && !normal_nak) |=> !verdict_q.forced_nak)
        else $error("non-in token forced");
    chk_port_upper: assert property (
        ce && rd && addr == usb_nak_pkg::ADDR_EP0_PORT |=> rdata_q[31:8] == 0)
        else $error("port upper bits set");
    chk_list_gap: assert property (
        ce && rd && addr[7:3] == 5'h0c |=> rdata_q[30:24] == 7'h00)
        else $error("list gap bits set");
    chk_rdata_idle: assert property (ce && !rd |=> rdata_q == 0)
        else $error("read data not idle");
    chk_nak_block: assert property (
        ce && in_pop ##0 s_nak_up |=> !in_byte_valid_q)
        else $error("pop during forced nak");
    chk_pop_empty: assert property (
        ce && in_pop && in_empty_q |=> !in_byte_valid_q)
        else $error("pop from empty");
endmodule
bind usb_nak_fifo usb_nak_fifo_asserts i_chk (.clk(clk), .nrst(nrst),
    .ce(ce), .addr(addr), .rd(rd), .rdata_q(rdata_q), .token(token),
    .normal_nak(normal_nak), .verdict_q(verdict_q), .in_pop(in_pop),
    .in_byte_valid_q(in_byte_valid_q), .in_empty_q(in_empty_q));
`default_nettype wire

// ### tb/usb_engine_model.sv
// Packet engine model: hands tokens and endpoint 0 bytes to the block.
// Assumes the bench calls its tasks; it drives only after rising edges.
`timescale 1ns/1ps
`default_nettype none
module usb_engine_model (
    // Clock
    input wire logic clk,
    // Toward the block
    output usb_nak_pkg::token_t token,
    output logic normal_nak,
    output logic in_pop,
    output logic out_push,
    output logic [7:0] out_byte
);
    // ------------------------------------------------------------
    // Transfers
    // ------------------------------------------------------------
    // Released token, normal_nak and out_byte show inverted values so nothing stale can match; strobes drop to zero.
    initial begin
        token = '0;
        normal_nak = 1'b0;
        in_pop = 1'b0;
        out_push = 1'b0;
        out_byte = 8'h00;
    end
    task send(input logic [3:0] ep, input logic in, nk, pop);
        @(posedge clk);
        token <= {1'b1, in, ep};
        normal_nak <= nk;
        @(posedge clk);
        token <= {1'b0, ~in, ~ep};
        normal_nak <= ~nk;
        in_pop <= pop;
        @(posedge clk);
        in_pop <= 1'b0;
    endtask
    task push(input logic [7:0] b, input logic pop);
        @(posedge clk);
        out_push <= 1'b1;
        in_pop <= pop;
        out_byte <= b;
        @(posedge clk);
        out_push <= 1'b0;
        in_pop <= 1'b0;
        out_byte <= ~b;
    endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the forced-NAK lists and endpoint 0 port.
// Assumes the package, checker and engine model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
$display("mismatch at %0t got %h exp %h", $time, g, e); end end
module tb;
    logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
    logic rd_seen = 1'b0, ev, in_pop, out_push, normal_nak;
    logic [7:0] addr = 8'h00, eb, b, out_byte, in_byte_q;
    logic [31:0] wdata = 32'h0, er, la, lb, rdata_q;
    logic in_byte_valid_q, in_empty_q, out_full_q;
    logic [3:0] r;
    logic exp_v[$];
    logic [31:0] exp_r[$];
    logic [7:0] exp_b[$], outq[$];
    usb_nak_pkg::token_t token;
    usb_nak_pkg::verdict_t verdict_q;
    int n_errors = 0, checked = 0;
    integer seed = 32'he24f;
    usb_nak_fifo #(.DEPTH(16)) i_dut (.clk(clk), .nrst(nrst), .ce(ce),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
        .token(token), .normal_nak(normal_nak), .verdict_q(verdict_q),
        .in_pop(in_pop), .in_byte_q(in_byte_q),
        .in_byte_valid_q(in_byte_valid_q), .in_empty_q(in_empty_q),
        .out_push(out_push), .out_byte(out_byte), .out_full_q(out_full_q));
    usb_engine_model i_eng (.clk(clk), .token(token),
        .normal_nak(normal_nak), .in_pop(in_pop), .out_push(out_push),
        .out_byte(out_byte));
    // ------------------------------------------------------------
    // Drivers and reference
    // ------------------------------------------------------------
    initial forever #10 clk = ~clk;
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [7:0] a, input logic [31:0] e);
        exp_r.push_back(e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // Own model of the slot match; zero slots are never candidates.
    function automatic logic hit(logic [31:0] l, logic [3:0] ep);
        hit = 1'b0;
        for (int i = 0; i < 6; i++) begin
            if (l[31] && l[i*4 +: 4] != 4'h0 && l[i*4 +: 4] == ep) hit = 1'b1;
        end
    endfunction
    // Every endpoint number, mostly IN, with random pacing.
    task sweep(input string nm);
        logic in, nk;
        for (int ep = 0; ep < 16; ep++) begin
            in = ($random(seed) & 3) != 0;
            nk = ($random(seed) & 7) == 0;
            exp_v.push_back(in && (hit(la, ep[3:0]) || hit(lb, ep[3:0])) || nk);
            i_eng.send(ep[3:0], in, nk, 1'b0);
            repeat ({$random(seed)} % 3) @(posedge clk);
        end
        $display("test %s done", nm);
    endtask
    task wrap_up;
        if (exp_v.size() + exp_r.size() + exp_b.size() != 0) n_errors++;
        $display("checked %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Results are matched against the oldest note of their kind.
    always @(posedge clk) begin
        rd_seen <= rd && ce;
        if (verdict_q.valid === 1'b1) begin
            ev = exp_v.size() ? exp_v.pop_front() : 1'bx;
            `CHK(verdict_q.forced_nak, ev);
        end
        if (rd_seen) begin
            er = exp_r.size() ? exp_r.pop_front() : 'x;
            `CHK(rdata_q, er);
        end
        if (in_byte_valid_q === 1'b1) begin
            eb = exp_b.size() ? exp_b.pop_front() : 'x;
            `CHK(in_byte_q, eb);
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        wrap_up;
    end
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(usb_nak_pkg::ADDR_LIST_A, 32'h0);
        rd_reg(usb_nak_pkg::ADDR_LIST_B, 32'h0);
        rd_reg(8'h70, 32'h0);
        la = 32'h8012_3456;
        lb = 32'h0078_9abc;
        wr_reg(usb_nak_pkg::ADDR_LIST_A, 32'hff12_3456);
        wr_reg(usb_nak_pkg::ADDR_LIST_B, lb);
        rd_reg(usb_nak_pkg::ADDR_LIST_A, la);
        rd_reg(usb_nak_pkg::ADDR_LIST_B, lb);
        // A write while the clock enable is low must leave the list alone.
        ce <= 1'b0;
        wr_reg(usb_nak_pkg::ADDR_LIST_A, 32'h0);
        ce <= 1'b1;
        rd_reg(usb_nak_pkg::ADDR_LIST_A, la);
        sweep("list_a");
        la = 32'h0012_3456;
        lb = 32'h8078_9abc;
        wr_reg(usb_nak_pkg::ADDR_LIST_A, la);
        wr_reg(usb_nak_pkg::ADDR_LIST_B, lb);
        sweep("list_b");
        r = 4'h1 + 4'({$random(seed)} % 15);
        la = {8'h80, {6{r}}};
        wr_reg(usb_nak_pkg::ADDR_LIST_A, la);
        sweep("random");
        for (int i = 0; i < 4; i++) begin
            b = $random(seed);
            exp_b.push_back(b);
            wr_reg(usb_nak_pkg::ADDR_EP0_PORT, {24'hff_ffff, b});
        end
        exp_v.push_back(1'b1);
        i_eng.send(r, 1'b1, 1'b0, 1'b1);
        for (int i = 0; i < 5; i++) begin
            b = $random(seed);
            outq.push_back(b);
            i_eng.push(b, i < 4);
        end
        // Four IN bytes drained, five OUT bytes waiting.
        rd_reg(usb_nak_pkg::ADDR_FIFO_STATUS, 32'h0000_0500);
        `CHK(in_empty_q, 1'b1);
        `CHK(out_full_q, 1'b0);
        for (int i = 0; i < 5; i++) rd_reg(usb_nak_pkg::ADDR_EP0_PORT, outq[i]);
        rd_reg(usb_nak_pkg::ADDR_EP0_PORT, 32'h0);
        $display("test ep0_port done");
        repeat (4) @(posedge clk);
        wrap_up;
    end
endmodule
`default_nettype wire
